// ==== fsc_cfg.svh ====
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register addresses on the 9-bit serial register port
`define FSC_ADDR_WIDTH      9
`define FSC_DATA_WIDTH      16
`define FSC_ADDR_MODE       9'h0c0
`define FSC_ADDR_ROW_WIDTH  9'h0c4
`define FSC_ADDR_WIN_EN     9'h0c3
`define FSC_ADDR_DARK_ROWS  9'h0c5
`define FSC_ADDR_FILLER     9'h0c6
`define FSC_ADDR_TICK_MULT  9'h0c7
`define FSC_ADDR_FRAME_LEN  9'h0c8
`define FSC_ADDR_EXPOSURE   9'h0c9
`define FSC_ADDR_GAIN       9'h0cc
`define FSC_ADDR_GATE       9'h0ce
`define FSC_ADDR_WIN_FIRST  9'h100
`define FSC_ADDR_WIN_LAST   9'h117

////////////////////////////////////////////////////////////////////////////////
// window definition store
`define FSC_NUM_WINDOWS     8
`define FSC_WORDS_PER_WIN   3
`define FSC_WIN_WORDS       24
`define FSC_WIN_IDX_BITS    5

////////////////////////////////////////////////////////////////////////////////
// field positions
`define FSC_MODE_SUBSAMPLE  7
`define FSC_MODE_BINNING    8
`define FSC_DARK_MSB        7
`define FSC_WIN_MASK_MSB    7
`define FSC_GAIN_COL_MSB    3
`define FSC_GAIN_COL_LSB    0
`define FSC_GAIN_FE_MSB     8
`define FSC_GAIN_FE_LSB     4
`define FSC_GATE_ROW_WIDTH  0
`define FSC_GATE_DARK       1
`define FSC_GATE_FILLER     2
`define FSC_GATE_INTEG      3
`define FSC_GATE_AMP        4
`define FSC_GATE_WINDOW     5
`define FSC_GATE_BLANK_SW   8

////////////////////////////////////////////////////////////////////////////////
// reset values and write masks
`define FSC_GATE_RESET      16'h003f
`define FSC_GATE_WMASK      16'h013f
`define FSC_WORD_ZERO       16'h0000

`endif

// ==== fsc_pkg.sv ====
package fsc_pkg;

    // active configuration handed to the image sequencer
    typedef struct packed {
        logic [15:0] row_width;
        logic [7:0]  dark_rows;
        logic [15:0] filler_rows;
        logic [15:0] tick_mult;
        logic [15:0] frame_period_len;
        logic [15:0] exposure;
        logic [3:0]  column_amp;
        logic [4:0]  frontend_amp;
        logic [7:0]  window_enable_mask;
        logic        subsample;
        logic        binning;
    } fsc_active_t;

    // window switch blanking tracker
    typedef enum logic [1:0] {
        FSC_RUN   = 2'b01,
        FSC_BLANK = 2'b10
    } fsc_state_t;

endpackage

// ==== fsc_shadow_stage.sv ====
`timescale 1ns/1ps

module fsc_shadow_stage #(
    parameter int          W        = 16,
    parameter logic [W-1:0] RESET_V = '0
) (
    input  wire logic         clock_i,
    input  wire logic         reset_n_i,
    input  wire logic         gate_i,
    input  wire logic         frame_start_i,
    input  wire logic [W-1:0] stage_i,
    output logic      [W-1:0] active_o
);

    // copy only on a frame boundary with the gate set, so a frame never sees a half update
    // regate reloads stored
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            active_o <= RESET_V;
        end else if (gate_i && frame_start_i) begin
            active_o <= stage_i;
        end
    end

endmodule // fsc_shadow_stage

// ==== fsc_window_store.sv ====
`timescale 1ns/1ps
`include "fsc_cfg.svh"

module fsc_window_store #(
    parameter int NUM_WORDS = `FSC_WIN_WORDS
) (
    input  wire logic                           clock_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           wr_i,
    input  wire logic [`FSC_WIN_IDX_BITS-1:0]   idx_i,
    input  wire logic [`FSC_DATA_WIDTH-1:0]     wdata_i,
    output logic      [`FSC_DATA_WIDTH-1:0]     rd_word_o,
    output logic      [NUM_WORDS*`FSC_DATA_WIDTH-1:0] defs_o
);

    logic [`FSC_DATA_WIDTH-1:0] mem [NUM_WORDS];

    // geometry is live: no gate and no frame boundary holds it back
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                mem[i] <= `FSC_WORD_ZERO;
            end
        end else if (wr_i) begin
            mem[idx_i] <= wdata_i;
        end
    end

    // flatten for the sequencer, word 0 in the low bits
    for (genvar g = 0; g < NUM_WORDS; g++) begin : g_flat
        assign defs_o[g*`FSC_DATA_WIDTH +: `FSC_DATA_WIDTH] = mem[g];
    end

    assign rd_word_o = mem[idx_i];

endmodule // fsc_window_store

// ==== fsc_top.sv ====
`timescale 1ns/1ps
`include "fsc_cfg.svh"

module fsc_top (
    input  wire logic                          clock_i,
    input  wire logic                          reset_n_i,
    input  wire logic [`FSC_ADDR_WIDTH-1:0]    spi_addr_i,
    input  wire logic [`FSC_DATA_WIDTH-1:0]    spi_wdata_i,
    input  wire logic                          spi_wr_i,
    input  wire logic                          spi_rd_i,
    input  wire logic                          frame_start_i,
    input  wire logic                          rolling_mode_i,
    output logic      [`FSC_DATA_WIDTH-1:0]    spi_rdata_o,
    output wire fsc_pkg::fsc_active_t          active_o,
    output wire [`FSC_WIN_WORDS*`FSC_DATA_WIDTH-1:0] window_defs_o,
    output logic                               blank_train_o
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic is_addr(input logic [`FSC_ADDR_WIDTH-1:0] a,
                                     input logic [`FSC_ADDR_WIDTH-1:0] off);
        is_addr = (a == off);
    endfunction

    fsc_pkg::fsc_active_t        stage;
    fsc_pkg::fsc_state_t         state;
    fsc_pkg::fsc_state_t         next_state;
    logic [`FSC_DATA_WIDTH-1:0]  gate_reg;
    logic [`FSC_DATA_WIDTH-1:0]  next_rdata;
    logic [`FSC_DATA_WIDTH-1:0]  win_rd_word;
    logic [`FSC_ADDR_WIDTH-1:0]  win_offset;
    logic                        win_hit;
    logic                        win_switch;

    wire hit_mode   = is_addr(spi_addr_i, `FSC_ADDR_MODE);
    wire hit_row    = is_addr(spi_addr_i, `FSC_ADDR_ROW_WIDTH);
    wire hit_win_en = is_addr(spi_addr_i, `FSC_ADDR_WIN_EN);
    wire hit_dark   = is_addr(spi_addr_i, `FSC_ADDR_DARK_ROWS);
    wire hit_filler = is_addr(spi_addr_i, `FSC_ADDR_FILLER);
    wire hit_mult   = is_addr(spi_addr_i, `FSC_ADDR_TICK_MULT);
    wire hit_frame  = is_addr(spi_addr_i, `FSC_ADDR_FRAME_LEN);
    wire hit_expo   = is_addr(spi_addr_i, `FSC_ADDR_EXPOSURE);
    wire hit_gain   = is_addr(spi_addr_i, `FSC_ADDR_GAIN);
    wire hit_gate   = is_addr(spi_addr_i, `FSC_ADDR_GATE);

    assign win_hit    = (spi_addr_i >= `FSC_ADDR_WIN_FIRST) && (spi_addr_i <= `FSC_ADDR_WIN_LAST);
    assign win_offset = spi_addr_i - `FSC_ADDR_WIN_FIRST;

    // gate bits
    wire gate_row    = gate_reg[`FSC_GATE_ROW_WIDTH];
    wire gate_dark   = gate_reg[`FSC_GATE_DARK];
    wire gate_filler = gate_reg[`FSC_GATE_FILLER];
    wire gate_integ  = gate_reg[`FSC_GATE_INTEG];
    wire gate_amp    = gate_reg[`FSC_GATE_AMP];
    wire gate_window = gate_reg[`FSC_GATE_WINDOW];
    wire blank_sw_en = gate_reg[`FSC_GATE_BLANK_SW];

    ////////////////////////////////////////////////////////////////////////////
    // gate register

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            gate_reg <= `FSC_GATE_RESET;
        end else if (spi_wr_i && hit_gate) begin
            gate_reg <= spi_wdata_i & `FSC_GATE_WMASK; // reserved bits stay zero
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // staged register file: writes always land here, gates never block storage

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            stage <= '0;
        end else if (spi_wr_i) begin
            if (hit_mode) begin
                stage.subsample <= spi_wdata_i[`FSC_MODE_SUBSAMPLE];
                stage.binning   <= spi_wdata_i[`FSC_MODE_BINNING];
            end
            if (hit_row) begin
                stage.row_width <= spi_wdata_i;
            end
            if (hit_win_en) begin
                stage.window_enable_mask <= spi_wdata_i[`FSC_WIN_MASK_MSB:0];
            end
            if (hit_dark) begin
                stage.dark_rows <= spi_wdata_i[`FSC_DARK_MSB:0];
            end
            if (hit_filler) begin
                stage.filler_rows <= spi_wdata_i;
            end
            if (hit_mult) begin
                stage.tick_mult <= spi_wdata_i;
            end
            if (hit_frame) begin
                stage.frame_period_len <= spi_wdata_i;
            end
            if (hit_expo) begin
                stage.exposure <= spi_wdata_i;
            end
            if (hit_gain) begin
                stage.column_amp   <= spi_wdata_i[`FSC_GAIN_COL_MSB:`FSC_GAIN_COL_LSB];
                stage.frontend_amp <= spi_wdata_i[`FSC_GAIN_FE_MSB:`FSC_GAIN_FE_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame-start transfer into the active set, one stage per gate

    fsc_shadow_stage #(.W(16)) u_row (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_row),
        .frame_start_i (frame_start_i),
        .stage_i       (stage.row_width),
        .active_o      (active_o.row_width)
    );

    fsc_shadow_stage #(.W(8)) u_dark (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_dark),
        .frame_start_i (frame_start_i),
        .stage_i       (stage.dark_rows),
        .active_o      (active_o.dark_rows)
    );

    fsc_shadow_stage #(.W(16)) u_filler (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_filler),
        .frame_start_i (frame_start_i),
        .stage_i       (stage.filler_rows),
        .active_o      (active_o.filler_rows)
    );

    fsc_shadow_stage #(.W(48)) u_integ (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_integ),
        .frame_start_i (frame_start_i),
        .stage_i       ({stage.tick_mult, stage.frame_period_len, stage.exposure}),
        .active_o      ({active_o.tick_mult, active_o.frame_period_len, active_o.exposure})
    );

    fsc_shadow_stage #(.W(9)) u_amp (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_amp),
        .frame_start_i (frame_start_i),
        .stage_i       ({stage.column_amp, stage.frontend_amp}),
        .active_o      ({active_o.column_amp, active_o.frontend_amp})
    );

    fsc_shadow_stage #(.W(10)) u_win_sel (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .gate_i        (gate_window),
        .frame_start_i (frame_start_i),
        .stage_i       ({stage.window_enable_mask, stage.subsample, stage.binning}),
        .active_o      ({active_o.window_enable_mask, active_o.subsample, active_o.binning})
    );

    ////////////////////////////////////////////////////////////////////////////
    // window definitions

    fsc_window_store u_windows (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .wr_i      (spi_wr_i && win_hit),
        .idx_i     (win_offset[`FSC_WIN_IDX_BITS-1:0]),
        .wdata_i   (spi_wdata_i),
        .rd_word_o (win_rd_word),
        .defs_o    (window_defs_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // window switch blanking

    assign win_switch = frame_start_i && gate_window && rolling_mode_i && blank_sw_en
                        && (stage.window_enable_mask != active_o.window_enable_mask);

    // blank lasts until the next frame start; a fresh switch there blanks again
    always_comb begin
        case (state)
            fsc_pkg::FSC_RUN: begin
                next_state = win_switch ? fsc_pkg::FSC_BLANK : fsc_pkg::FSC_RUN;
            end
            fsc_pkg::FSC_BLANK: begin
                if (frame_start_i) begin
                    next_state = win_switch ? fsc_pkg::FSC_BLANK : fsc_pkg::FSC_RUN;
                end else begin
                    next_state = fsc_pkg::FSC_BLANK;
                end
            end
            default: begin
                next_state = fsc_pkg::FSC_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state         <= fsc_pkg::FSC_RUN;
            blank_train_o <= 1'b0;
        end else begin
            state         <= next_state;
            blank_train_o <= (next_state == fsc_pkg::FSC_BLANK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read back: staged values, so software sees what it wrote even while frozen

    assign next_rdata =
        hit_mode   ? {7'h00, stage.binning, stage.subsample, 7'h00} :
        hit_row    ? stage.row_width :
        hit_win_en ? {8'h00, stage.window_enable_mask} :
        hit_dark   ? {8'h00, stage.dark_rows} :
        hit_filler ? stage.filler_rows :
        hit_mult   ? stage.tick_mult :
        hit_frame  ? stage.frame_period_len :
        hit_expo   ? stage.exposure :
        hit_gain   ? {7'h00, stage.frontend_amp, stage.column_amp} :
        hit_gate   ? gate_reg :
        win_hit    ? win_rd_word :
                     `FSC_WORD_ZERO;

    // unmapped addresses read zero
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            spi_rdata_o <= `FSC_WORD_ZERO;
        end else if (spi_rd_i) begin
            spi_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_integ_load: assert property (gate_integ && frame_start_i
        |=> active_o.exposure == $past(stage.exposure)
            && active_o.frame_period_len == $past(stage.frame_period_len))
        else $error("integration group not loaded at frame start");

    a_integ_hold: assert property (!(gate_integ && frame_start_i)
        |=> $stable(active_o.exposure) && $stable(active_o.tick_mult))
        else $error("integration group changed without gated frame start");

    a_amp_load: assert property (gate_amp && frame_start_i
        |=> active_o.column_amp == $past(stage.column_amp)
            && active_o.frontend_amp == $past(stage.frontend_amp))
        else $error("amplifier group not loaded");

    a_dark_hold: assert property (!gate_dark ##0 frame_start_i
        |=> $stable(active_o.dark_rows))
        else $error("dark rows changed while gate clear");

    a_row_load: assert property (gate_row && frame_start_i
        |=> active_o.row_width == $past(stage.row_width))
        else $error("row width not loaded");

    a_filler_load: assert property (gate_filler && frame_start_i
        |=> active_o.filler_rows == $past(stage.filler_rows))
        else $error("filler rows not loaded");

    a_mask_load: assert property (gate_window && frame_start_i
        |=> active_o.window_enable_mask == $past(stage.window_enable_mask))
        else $error("window mask not loaded");

    a_window_live: assert property (spi_wr_i && spi_addr_i == `FSC_ADDR_WIN_FIRST
        |=> window_defs_o[15:0] == $past(spi_wdata_i))
        else $error("window geometry not live");

    a_blank_start: assert property (win_switch |=> blank_train_o)
        else $error("window switch did not blank");

    a_blank_span: assert property (blank_train_o && !frame_start_i |=> blank_train_o)
        else $error("blank ended inside the frame");

    a_resize_quiet: assert property (!blank_train_o && !win_switch
        |=> !blank_train_o)
        else $error("blank without window switch");

    a_gate_reset: assert property ($past(!reset_n_i) |-> gate_reg == `FSC_GATE_RESET)
        else $error("gates not set after reset");

    c_blank_frame: cover property (win_switch ##1 blank_train_o [*3] ##1 !blank_train_o);
    c_frozen_write: cover property (!gate_integ && spi_wr_i && hit_expo ##[1:20] frame_start_i);
    c_regate_load: cover property ($rose(gate_integ) ##[1:20] frame_start_i);

endmodule // fsc_top

// ==== fsc_host_model.sv ====
`timescale 1ns/1ps
`include "fsc_cfg.svh"

// serial register host: one access per call, all changes on the falling edge
module fsc_host_model (
    input  wire logic                       clock_i,
    output logic      [`FSC_ADDR_WIDTH-1:0] spi_addr_o,
    output logic      [`FSC_DATA_WIDTH-1:0] spi_wdata_o,
    output logic                            spi_wr_o,
    output logic                            spi_rd_o
);
    // idle bus at time zero
    initial begin
        spi_addr_o  = '0;
        spi_wdata_o = '0;
        spi_wr_o    = 1'b0;
        spi_rd_o    = 1'b0;
    end

    // strobe held for one rising edge; released lines show the inverse so a
    // stale address or data word can never pass for a live one
    task automatic access(input logic wr, input logic [8:0] a, input logic [15:0] d);
        @(negedge clock_i);
        spi_addr_o  = a;
        spi_wdata_o = d;
        spi_wr_o    = wr;
        spi_rd_o    = !wr;
        @(negedge clock_i);
        spi_wr_o    = 1'b0;
        spi_rd_o    = 1'b0;
        spi_addr_o  = ~a;
        spi_wdata_o = ~d;
    endtask
endmodule // fsc_host_model

// ==== tb_frame_synced_config_shadow.sv ====
`timescale 1ns/1ps
`include "fsc_cfg.svh"

module tb_frame_synced_config_shadow;
    typedef struct {
        logic                 kind;
        fsc_pkg::fsc_active_t act;
        logic                 blank;
        logic [383:0]         defs;
        logic [15:0]          rd;
    } fsc_tb_note_t;

    logic                 clock_i = 1'b0;
    logic                 reset_n_i = 1'b0;
    logic                 frame_start = 1'b0;
    logic                 rolling = 1'b0;
    logic [8:0]           spi_addr;
    logic [15:0]          spi_wdata;
    logic                 spi_wr;
    logic                 spi_rd;
    logic [15:0]          spi_rdata;
    fsc_pkg::fsc_active_t active;
    logic [383:0]         window_defs;
    logic                 blank_train;
    logic                 rd_q = 1'b0;
    logic                 fs_q = 1'b0;
    logic [15:0]          regs [512];
    fsc_pkg::fsc_active_t exp_act;
    logic [383:0]         exp_defs;
    fsc_tb_note_t         note_q [$];
    int                   bad_count = 0;
    int                   n_compared = 0;
    int                   seed = 77;
    localparam logic [8:0]  FN_ADDR [9] = '{9'h0c0, 9'h0c3, 9'h0c4, 9'h0c5, 9'h0c6,
                                           9'h0c7, 9'h0c8, 9'h0c9, 9'h0cc};
    localparam logic [15:0] FN_MASK [9] = '{16'h0180, 16'h00ff, 16'hffff, 16'h00ff,
                                           16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h01ff};

    always #12.5 clock_i = ~clock_i;

    fsc_host_model u_host (
        .clock_i     (clock_i),
        .spi_addr_o  (spi_addr),
        .spi_wdata_o (spi_wdata),
        .spi_wr_o    (spi_wr),
        .spi_rd_o    (spi_rd)
    );

    fsc_top u_dut (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .spi_addr_i     (spi_addr),
        .spi_wdata_i    (spi_wdata),
        .spi_wr_i       (spi_wr),
        .spi_rd_i       (spi_rd),
        .frame_start_i  (frame_start),
        .rolling_mode_i (rolling),
        .spi_rdata_o    (spi_rdata),
        .active_o       (active),
        .window_defs_o  (window_defs),
        .blank_train_o  (blank_train)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        // a note never taken means a result that never showed up
        if (note_q.size() != 0) begin
            $display("wrong value note queue expected 0 seen %0d", note_q.size());
            bad_count++;
        end
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [383:0] exp, input logic [383:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // model keeps the staged copy; window words are live at once
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        regs[a] = d;
        if (a >= `FSC_ADDR_WIN_FIRST && a <= `FSC_ADDR_WIN_LAST) begin
            exp_defs[16*(int'(a) - int'(`FSC_ADDR_WIN_FIRST)) +: 16] = d;
        end
        u_host.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        fsc_tb_note_t n;
        n.kind = 1'b0;
        n.rd   = e;
        note_q.push_back(n);
        u_host.access(1'b0, a, 16'h0000);
    endtask

    // gated load of every group, blank decided against the old active mask
    task automatic frame();
        fsc_tb_note_t n;
        logic [15:0]  g;
        g = regs[`FSC_ADDR_GATE];
        n.kind  = 1'b1;
        n.rd    = '0;
        n.blank = g[`FSC_GATE_WINDOW] & g[`FSC_GATE_BLANK_SW] & rolling
                  & (regs[`FSC_ADDR_WIN_EN][7:0] != exp_act.window_enable_mask);
        if (g[`FSC_GATE_ROW_WIDTH]) exp_act.row_width = regs[`FSC_ADDR_ROW_WIDTH];
        if (g[`FSC_GATE_DARK]) exp_act.dark_rows = regs[`FSC_ADDR_DARK_ROWS][7:0];
        if (g[`FSC_GATE_FILLER]) exp_act.filler_rows = regs[`FSC_ADDR_FILLER];
        if (g[`FSC_GATE_INTEG]) begin
            exp_act.tick_mult        = regs[`FSC_ADDR_TICK_MULT];
            exp_act.frame_period_len = regs[`FSC_ADDR_FRAME_LEN];
            exp_act.exposure         = regs[`FSC_ADDR_EXPOSURE];
        end
        if (g[`FSC_GATE_AMP]) begin
            exp_act.column_amp   = regs[`FSC_ADDR_GAIN][3:0];
            exp_act.frontend_amp = regs[`FSC_ADDR_GAIN][8:4];
        end
        if (g[`FSC_GATE_WINDOW]) begin
            exp_act.window_enable_mask = regs[`FSC_ADDR_WIN_EN][7:0];
            exp_act.subsample          = regs[`FSC_ADDR_MODE][7];
            exp_act.binning            = regs[`FSC_ADDR_MODE][8];
        end
        n.act  = exp_act;
        n.defs = exp_defs;
        note_q.push_back(n);
        @(negedge clock_i);
        frame_start = 1'b1;
        @(negedge clock_i);
        frame_start = 1'b0;
    endtask

    task automatic fill_random();
        for (int i = 0; i < 9; i++) begin
            wr(FN_ADDR[i], 16'($random(seed)) & FN_MASK[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // results appear at the taking edge; look at the falling edge after it
    always @(posedge clock_i) begin
        rd_q <= spi_rd;
        fs_q <= frame_start;
    end

    always @(negedge clock_i) begin
        fsc_tb_note_t n;
        if (rd_q || fs_q) begin
            if (note_q.size() == 0) begin
                $display("wrong value note queue expected entry seen none");
                bad_count++;
            end else begin
                n = note_q.pop_front();
                if (!n.kind) begin
                    check("read data", 384'(n.rd), 384'(spi_rdata));
                end else begin
                    check("active set", 384'(n.act), 384'(active));
                    check("blank", 384'(n.blank), 384'(blank_train));
                    check("window defs", n.defs, window_defs);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #(25 * 20000);
        bad_count++;
        end_of_test();
    end

    initial begin
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[`FSC_ADDR_GATE] = 16'h003f;
        exp_act  = '0;
        exp_defs = '0;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        reset_n_i = 1'b1;
        rd(`FSC_ADDR_GATE, 16'h003f);
        frame();
        for (int g = 0; g < 6; g++) begin
            wr(`FSC_ADDR_GATE, 16'h003f & ~(16'h0001 << g));
            fill_random();
            rd(FN_ADDR[g + 3], regs[FN_ADDR[g + 3]]);
            frame();
            wr(`FSC_ADDR_GATE, 16'h003f);
            frame();
        end
        // unused gate bits read as zero
        wr(`FSC_ADDR_GATE, 16'hffff);
        regs[`FSC_ADDR_GATE] = 16'h013f;
        rd(`FSC_ADDR_GATE, 16'h013f);
        // geometry written with the window gate cleared
        wr(`FSC_ADDR_GATE, 16'h011f);
        for (int k = 0; k < 24; k++) wr(`FSC_ADDR_WIN_FIRST + 9'(k), 16'($random(seed)));
        rd(`FSC_ADDR_WIN_LAST, regs[`FSC_ADDR_WIN_LAST]);
        rd(9'h118, 16'h0000);
        frame();
        // rolling mode, one window at a time
        rolling = 1'b1;
        wr(`FSC_ADDR_GATE, 16'h013f);
        wr(`FSC_ADDR_WIN_EN, 16'h0001);
        frame();
        frame();
        for (int k = 1; k < 8; k++) begin
            wr(`FSC_ADDR_WIN_EN, 16'h0001 << k);
            frame();
        end
        frame();
        // resizing the active window is not a switch
        wr(`FSC_ADDR_WIN_FIRST + 9'd21, 16'($random(seed)));
        frame();
        wr(`FSC_ADDR_GATE, 16'h003f);
        wr(`FSC_ADDR_WIN_EN, 16'h0001);
        frame();
        // global mode with all eight windows, no blank
        rolling = 1'b0;
        wr(`FSC_ADDR_GATE, 16'h013f);
        wr(`FSC_ADDR_WIN_EN, 16'h00ff);
        frame();
        // let the checker take the last note before the verdict
        repeat (2) @(negedge clock_i);
        end_of_test();
    end
endmodule // tb_frame_synced_config_shadow
